// ### kp_pkg.sv
package kp_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int EDIT_TIMEOUT_MS = 5000;
	localparam int EDIT_TIMEOUT_CYC = EDIT_TIMEOUT_MS * CYC_PER_MS;
	localparam int HOLD_MS = 500;
	localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
	localparam int REPEAT_MS = 100;
	localparam int REPEAT_CYC = REPEAT_MS * CYC_PER_MS;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
	localparam int TIMER_W = 27;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DRIVE_STATUS = 8'h04;
	localparam logic [7:0] OFS_OUT_FREQ = 8'h08;
	localparam logic [7:0] OFS_FREQ_REF = 8'h0c;
	localparam logic [7:0] OFS_UPPER_LIMIT = 8'h10;
	localparam logic [7:0] OFS_LOWER_LIMIT = 8'h14;
	localparam logic [7:0] OFS_MON_SELECT = 8'h18;
	localparam logic [7:0] OFS_MON_VALUE = 8'h1c;
	localparam logic [7:0] OFS_PID_DIGITS = 8'h20;
	localparam logic [7:0] OFS_KP_STATUS = 8'h24;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_SHOW_MON = 0;
	localparam int CTRL_SLOT_LSB = 1;
	localparam int DS_FAULT = 0;
	localparam int DS_RUNNING = 1;
	localparam int DS_REVERSE = 2;
	localparam int DS_RUN_CMD = 3;
	localparam int DS_STOPPING = 4;
	localparam int DS_SEQ_EXT = 5;
	localparam int DS_REF_EXT = 6;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_DIGIT_LSB = 2;
	localparam int ST_PWR_FLASH = 5;
	localparam int ST_REF_UPDATED = 8;
	localparam int ST_MON_CODE_LSB = 12;
	localparam logic [19:0] UPPER_LIMIT_RST = 20'h06000;
	localparam logic [19:0] LOWER_LIMIT_RST = 20'h00000;
	localparam logic [19:0] FREQ_REF_RST = 20'h00000;
	localparam logic [2:0] PID_DIGITS_RST = 3'h5;
	localparam logic [2:0] LAST_DIGIT = 3'h4;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [9:0] ANALOG_FULL = 10'h3ff;

	// ----------------------------------------------------------------
	// Modes and monitor codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_REF_SHOW = 2'b00,
		ST_REF_EDIT = 2'b01
	} kp_state_t;

	typedef enum logic [1:0] {
		DM_REF = 2'h0,
		DM_EDIT = 2'h1,
		DM_OUT_FREQ = 2'h2,
		DM_MONITOR = 2'h3
	} disp_mode_t;

	localparam logic [2:0] MON_NONE = 3'h0;
	localparam logic [2:0] MON_PID = 3'h5;
	localparam logic [2:0] MON_ANALOG_ONE = 3'h6;
	localparam logic [2:0] MON_ANALOG_TWO = 3'h7;

endpackage

// ### key_repeat.sv
module key_repeat #(
	parameter int HOLD_CYCLES = 10000000,
	parameter int REPEAT_CYCLES = 2000000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic key,
	output logic press
);

	localparam logic [kp_pkg::TIMER_W-1:0] HOLD_LAST = kp_pkg::TIMER_W'(HOLD_CYCLES - 1);
	localparam logic [kp_pkg::TIMER_W-1:0] REP_LAST = kp_pkg::TIMER_W'(REPEAT_CYCLES - 1);

	logic key_prev;
	logic repeating;
	logic [kp_pkg::TIMER_W-1:0] count;

	wire logic edge_rise = key & ~key_prev;
	wire logic limit = repeating ? (count == REP_LAST) : (count == HOLD_LAST);
	wire logic tick = key & key_prev & limit;

	// Press on the edge, then again after the hold and at each repeat
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_prev <= 1'b0;
			repeating <= 1'b0;
			count <= '0;
			press <= 1'b0;
		end
		else
		begin
			key_prev <= key;
			press <= edge_rise | tick;
			if (!key | edge_rise | tick)
				count <= '0;
			else
				count <= count + 1'b1;
			if (!key)
				repeating <= 1'b0;
			else if (tick)
				repeating <= 1'b1;
		end
	end

endmodule

// ### keypad_led_display_control.sv
module keypad_led_display_control #(
	parameter int EDIT_TIMEOUT_CYCLES = kp_pkg::EDIT_TIMEOUT_CYC,
	parameter int HOLD_CYCLES = kp_pkg::HOLD_CYC,
	parameter int REPEAT_CYCLES = kp_pkg::REPEAT_CYC,
	parameter int BLINK_HALF_CYCLES = kp_pkg::BLINK_HALF_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic KEY_UP,
	input wire logic KEY_DOWN,
	input wire logic KEY_DIGIT,
	input wire logic KEY_ENTER,
	output logic [19:0] DISP_VALUE,
	output logic [4:0] DISP_BLANK,
	output logic [1:0] DISP_MODE,
	output logic FAULT_LED,
	output logic FORWARD_INDICATOR,
	output logic REVERSE_INDICATOR,
	output logic RUN_LED,
	output logic SEQUENCE_SOURCE_INDICATOR,
	output logic REFERENCE_SOURCE_INDICATOR,
	output logic FAULT_RESET
);

	localparam logic [kp_pkg::TIMER_W-1:0] TIMEOUT_LAST =
		kp_pkg::TIMER_W'(EDIT_TIMEOUT_CYCLES - 1);
	localparam logic [kp_pkg::TIMER_W-1:0] BLINK_LAST =
		kp_pkg::TIMER_W'(BLINK_HALF_CYCLES - 1);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	wire logic rst_n = rst_sync[1];

	// Asynchronous assert, release through two flops
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [3:0] ctrl;
	logic [6:0] drive_status;
	logic [19:0] out_freq;
	logic [19:0] freq_ref;
	logic [19:0] upper_limit;
	logic [19:0] lower_limit;
	logic [14:0] mon_select;
	logic [19:0] mon_value;
	logic [2:0] pid_digits;
	logic ref_updated;
	logic powerup_flash;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire logic access = PSEL & PENABLE & ~PREADY;
	wire logic wr = access & PWRITE;
	wire logic hit_ctrl = PADDR == kp_pkg::OFS_CTRL;
	wire logic hit_ds = PADDR == kp_pkg::OFS_DRIVE_STATUS;
	wire logic hit_of = PADDR == kp_pkg::OFS_OUT_FREQ;
	wire logic hit_ref = PADDR == kp_pkg::OFS_FREQ_REF;
	wire logic hit_up = PADDR == kp_pkg::OFS_UPPER_LIMIT;
	wire logic hit_lo = PADDR == kp_pkg::OFS_LOWER_LIMIT;
	wire logic hit_ms = PADDR == kp_pkg::OFS_MON_SELECT;
	wire logic hit_mv = PADDR == kp_pkg::OFS_MON_VALUE;
	wire logic hit_pd = PADDR == kp_pkg::OFS_PID_DIGITS;
	wire logic hit_st = PADDR == kp_pkg::OFS_KP_STATUS;
	wire logic mapped = hit_ctrl | hit_ds | hit_of | hit_ref | hit_up | hit_lo |
		hit_ms | hit_mv | hit_pd | hit_st;

	// ----------------------------------------------------------------
	// Keys
	// ----------------------------------------------------------------
	wire logic [1:0] step_keys = {KEY_DOWN, KEY_UP};
	logic [1:0] step_press;
	logic digit_prev;
	logic enter_prev;
	wire logic up_press = step_press[0];
	wire logic down_press = step_press[1];
	wire logic digit_press = KEY_DIGIT & ~digit_prev;
	wire logic enter_press = KEY_ENTER & ~enter_prev;
	wire logic any_press = up_press | down_press | digit_press | enter_press;

	// One repeat engine per step key
	genvar k;
	generate
		for (k = 0; k < 2; k++)
		begin : g_step
			key_repeat #(
				.HOLD_CYCLES(HOLD_CYCLES),
				.REPEAT_CYCLES(REPEAT_CYCLES)
			) u_rep (
				.clk(SYS_CLK),
				.rst_n(rst_n),
				.key(step_keys[k]),
				.press(step_press[k])
			);
		end
	endgenerate

	// Edge detect for single-shot keys
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			digit_prev <= 1'b0;
			enter_prev <= 1'b0;
		end
		else
		begin
			digit_prev <= KEY_DIGIT;
			enter_prev <= KEY_ENTER;
		end
	end

	// ----------------------------------------------------------------
	// Blink divider
	// ----------------------------------------------------------------
	logic [kp_pkg::TIMER_W-1:0] blink_count;
	logic blink;
	wire logic blink_tick = blink_count == BLINK_LAST;

	// One shared phase keeps every flashing element in step
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			blink_count <= '0;
			blink <= 1'b1;
		end
		else
		begin
			blink_count <= blink_tick ? '0 : blink_count + 1'b1;
			if (blink_tick)
				blink <= ~blink;
		end
	end

	// ----------------------------------------------------------------
	// Reference editing
	// ----------------------------------------------------------------
	// BCD step at one digit with carry or borrow; bit 20 flags overflow
	function automatic logic [20:0] bcd_step(input logic [19:0] val,
		input logic [2:0] dig, input logic up);
		logic [19:0] res;
		logic [3:0] nib;
		logic c;
		res = val;
		c = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			nib = val[4*i +: 4];
			if (i == int'(dig))
				c = 1'b1;
			if (up && c && nib == kp_pkg::BCD_MAX)
				nib = 4'h0;
			else if (up && c)
			begin
				nib = nib + 4'h1;
				c = 1'b0;
			end
			else if (!up && c && nib == 4'h0)
				nib = kp_pkg::BCD_MAX;
			else if (!up && c)
			begin
				nib = nib - 4'h1;
				c = 1'b0;
			end
			res[4*i +: 4] = nib;
		end
		return {c, res};
	endfunction

	kp_pkg::kp_state_t state;
	kp_pkg::kp_state_t next_state;
	logic [19:0] edit_val;
	logic [2:0] digit;
	logic [kp_pkg::TIMER_W-1:0] edit_timer;

	wire logic editing = state == kp_pkg::ST_REF_EDIT;
	wire logic [20:0] up_step = bcd_step(edit_val, digit, 1'b1);
	wire logic [20:0] down_step = bcd_step(edit_val, digit, 1'b0);
	wire logic up_wrap = up_step[20] | (up_step[19:0] > upper_limit);
	wire logic down_wrap = down_step[20] | (down_step[19:0] < lower_limit);
	wire logic [19:0] up_val = up_wrap ? lower_limit : up_step[19:0];
	wire logic [19:0] down_val = down_wrap ? upper_limit : down_step[19:0];
	wire logic timeout = editing & (edit_timer == TIMEOUT_LAST);
	wire logic commit = editing & enter_press;

	// Mode transitions
	always_comb
	begin
		next_state = state;
		unique case (state)
			kp_pkg::ST_REF_SHOW:
				if (up_press | down_press)
					next_state = kp_pkg::ST_REF_EDIT;
			kp_pkg::ST_REF_EDIT:
				if (commit | timeout)
					next_state = kp_pkg::ST_REF_SHOW;
		endcase
	end

	// Edit value, digit and timeout; timer restarts on any key
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= kp_pkg::ST_REF_SHOW;
			edit_val <= kp_pkg::FREQ_REF_RST;
			digit <= 3'h0;
			edit_timer <= '0;
		end
		else
		begin
			state <= next_state;
			edit_timer <= (!editing | any_press) ? '0 : edit_timer + 1'b1;
			if (!editing)
			begin
				edit_val <= freq_ref;
				digit <= 3'h0;
			end
			else if (up_press)
				edit_val <= up_val;
			else if (down_press)
				edit_val <= down_val;
			else if (digit_press)
				digit <= (digit == kp_pkg::LAST_DIGIT) ? 3'h0 : digit + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Monitor formatting
	// ----------------------------------------------------------------
	wire logic [2:0] slot = ctrl[kp_pkg::CTRL_SLOT_LSB +: 3];
	wire logic [2:0] slot_ok = (slot > kp_pkg::LAST_DIGIT) ? kp_pkg::LAST_DIGIT : slot;
	wire logic [3:0] slot_pos = 4'(kp_pkg::LAST_DIGIT - slot_ok);
	wire logic [2:0] mon_code = mon_select[3*slot_pos +: 3];
	wire logic is_analog = (mon_code == kp_pkg::MON_ANALOG_ONE) |
		(mon_code == kp_pkg::MON_ANALOG_TWO);
	wire logic [16:0] pct_num = 17'(mon_value[9:0]) * 17'd100 + 17'(kp_pkg::ANALOG_FULL >> 1);
	wire logic [6:0] pct = 7'(pct_num / 17'(kp_pkg::ANALOG_FULL));
	wire logic [3:0] pct_hund = 4'(pct / 7'd100);
	wire logic [3:0] pct_tens = 4'((pct % 7'd100) / 7'd10);
	wire logic [3:0] pct_unit = 4'(pct % 7'd10);
	wire logic [19:0] pct_bcd = {8'h00, pct_hund, pct_tens, pct_unit};
	wire logic [19:0] mon_bcd = is_analog ? pct_bcd : mon_value;
	logic [4:0] pid_mask;
	logic [4:0] edit_mask;

	// Blank digits above the configured PID width; flashing edit digit
	generate
		for (k = 0; k < 5; k++)
		begin : g_digit
			assign pid_mask[k] = (mon_code == kp_pkg::MON_PID) &&
				(k >= int'(pid_digits));
			assign edit_mask[k] = editing && (k == int'(digit)) && !blink;
		end
	endgenerate

	wire logic show_mon = ctrl[kp_pkg::CTRL_SHOW_MON] & ~editing;
	wire logic running = drive_status[kp_pkg::DS_RUNNING];
	wire logic [4:0] mon_mask = (mon_code == kp_pkg::MON_NONE) ? 5'h1f : pid_mask;
	wire logic [4:0] next_blank = show_mon ? mon_mask : edit_mask;
	wire kp_pkg::disp_mode_t next_mode = editing ? kp_pkg::DM_EDIT :
		show_mon ? kp_pkg::DM_MONITOR :
		running ? kp_pkg::DM_OUT_FREQ : kp_pkg::DM_REF;
	wire logic [19:0] next_value = editing ? edit_val :
		show_mon ? mon_bcd :
		running ? out_freq : freq_ref;

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	wire logic reverse_indicator = drive_status[kp_pkg::DS_REVERSE];
	wire logic run_cmd = drive_status[kp_pkg::DS_RUN_CMD];
	wire logic stopping = drive_status[kp_pkg::DS_STOPPING];
	wire logic idle_dir = ~(running & run_cmd);
	wire logic next_fwd = !reverse_indicator & (idle_dir ? blink : 1'b1);
	wire logic next_rev = reverse_indicator & (idle_dir ? blink : 1'b1);
	wire logic next_run = stopping ? blink : running;

	// Power-up flash overrides until status arrives or a key is used
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			FAULT_LED <= 1'b0;
			FORWARD_INDICATOR <= 1'b0;
			REVERSE_INDICATOR <= 1'b0;
			RUN_LED <= 1'b0;
			SEQUENCE_SOURCE_INDICATOR <= 1'b0;
			REFERENCE_SOURCE_INDICATOR <= 1'b0;
			DISP_VALUE <= kp_pkg::FREQ_REF_RST;
			DISP_BLANK <= 5'h00;
			DISP_MODE <= kp_pkg::DM_REF;
			FAULT_RESET <= 1'b0;
		end
		else
		begin
			FAULT_LED <= powerup_flash ? blink : drive_status[kp_pkg::DS_FAULT];
			FORWARD_INDICATOR <= powerup_flash ? blink : next_fwd;
			REVERSE_INDICATOR <= powerup_flash ? blink : next_rev;
			RUN_LED <= powerup_flash ? blink : next_run;
			SEQUENCE_SOURCE_INDICATOR <= powerup_flash ? blink :
				drive_status[kp_pkg::DS_SEQ_EXT];
			REFERENCE_SOURCE_INDICATOR <= powerup_flash ? blink :
				drive_status[kp_pkg::DS_REF_EXT];
			DISP_VALUE <= next_value;
			DISP_BLANK <= next_blank;
			DISP_MODE <= next_mode;
			FAULT_RESET <= digit_press & ~editing & drive_status[kp_pkg::DS_FAULT];
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	wire logic st_clear = wr & hit_st & PWDATA[kp_pkg::ST_REF_UPDATED];

	// Software config; commit wins over a bus write to the reference
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= 4'h0;
			drive_status <= 7'h00;
			out_freq <= 20'h00000;
			freq_ref <= kp_pkg::FREQ_REF_RST;
			upper_limit <= kp_pkg::UPPER_LIMIT_RST;
			lower_limit <= kp_pkg::LOWER_LIMIT_RST;
			mon_select <= 15'h0000;
			mon_value <= 20'h00000;
			pid_digits <= kp_pkg::PID_DIGITS_RST;
			ref_updated <= 1'b0;
			powerup_flash <= 1'b1;
		end
		else
		begin
			if (wr & hit_ctrl)
				ctrl <= PWDATA[3:0];
			if (wr & hit_ds)
				drive_status <= PWDATA[6:0];
			if (wr & hit_of)
				out_freq <= PWDATA[19:0];
			if (commit)
				freq_ref <= edit_val;
			else if (wr & hit_ref)
				freq_ref <= PWDATA[19:0];
			if (wr & hit_up)
				upper_limit <= PWDATA[19:0];
			if (wr & hit_lo)
				lower_limit <= PWDATA[19:0];
			if (wr & hit_ms)
				mon_select <= PWDATA[14:0];
			if (wr & hit_mv)
				mon_value <= PWDATA[19:0];
			if (wr & hit_pd)
				pid_digits <= PWDATA[2:0];
			if (commit)
				ref_updated <= 1'b1;
			else if (st_clear)
				ref_updated <= 1'b0;
			if ((wr & hit_ds) | any_press)
				powerup_flash <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data and response
	// ----------------------------------------------------------------
	wire logic [31:0] status_word = {17'h0, mon_code, 3'h0, ref_updated, 2'h0,
		powerup_flash, digit, state};
	wire logic [31:0] rdata = hit_ctrl ? {28'h0, ctrl} :
		hit_ds ? {25'h0, drive_status} :
		hit_of ? {12'h0, out_freq} :
		hit_ref ? {12'h0, freq_ref} :
		hit_up ? {12'h0, upper_limit} :
		hit_lo ? {12'h0, lower_limit} :
		hit_ms ? {17'h0, mon_select} :
		hit_mv ? {12'h0, mon_value} :
		hit_pd ? {29'h0, pid_digits} :
		hit_st ? status_word : 32'h0;

	// One wait state; unmapped addresses answer with an error
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= access;
			PSLVERR <= access & ~mapped;
			if (access & ~PWRITE)
				PRDATA <= rdata;
		end
	end

endmodule

// ### keypad_led_display_control_properties.sv
// ------------------------------------------------
// Port checker for the keypad display controller
// ------------------------------------------------
module keypad_led_display_control_properties #(
	parameter int EDIT_TIMEOUT_CYCLES = 200
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic KEY_UP,
	input wire logic KEY_DOWN,
	input wire logic KEY_DIGIT,
	input wire logic KEY_ENTER,
	input wire logic [1:0] DISP_MODE,
	input wire logic FAULT_LED,
	input wire logic FORWARD_INDICATOR,
	input wire logic REVERSE_INDICATOR,
	input wire logic RUN_LED,
	input wire logic SEQUENCE_SOURCE_INDICATOR,
	input wire logic REFERENCE_SOURCE_INDICATOR
);
	logic in_edit;
	logic any_key;
	int idle;

	// Edit mode and key activity as seen at the pins
	assign in_edit = DISP_MODE == kp_pkg::DM_EDIT;
	assign any_key = KEY_UP | KEY_DOWN | KEY_DIGIT | KEY_ENTER;

	// Idle time in edit, counted from key release, so it trails the design timer
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			idle <= 0;
		else if (!in_edit || any_key)
			idle <= 0;
		else
			idle <= idle + 1;
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_ready_follows: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("ready missing after access phase");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("error flag without ready");
	// Both direction lamps together only in the power-up flash, where all lamps match
	a_dir_exclusive: assert property (!(FORWARD_INDICATOR && REVERSE_INDICATOR) ||
		(FAULT_LED && RUN_LED && SEQUENCE_SOURCE_INDICATOR && REFERENCE_SOURCE_INDICATOR))
		else $error("forward and reverse lit together");
	a_powerup_lit: assert property ($rose(RST_N) |-> ##[2:4] (FAULT_LED &&
		FORWARD_INDICATOR && REVERSE_INDICATOR && RUN_LED && SEQUENCE_SOURCE_INDICATOR &&
		REFERENCE_SOURCE_INDICATOR))
		else $error("indicators not lit after power-up");
	a_edit_entry: assert property ($rose(in_edit) |-> $past(KEY_UP, 2) ||
		$past(KEY_DOWN, 2) || $past(KEY_UP, 3) || $past(KEY_DOWN, 3))
		else $error("edit mode entered without up or down");
	a_edit_bound: assert property (idle <= EDIT_TIMEOUT_CYCLES + 4)
		else $error("edit mode outlived its timeout");
	a_edit_exit: assert property ($fell(in_edit) |-> $past(KEY_ENTER, 2) ||
		$past(KEY_ENTER, 3) || idle >= EDIT_TIMEOUT_CYCLES - 12)
		else $error("edit mode left without commit or timeout");

	c_edit: cover property ($rose(in_edit));
	c_timeout: cover property ($fell(in_edit) && idle > 100);
	c_slverr: cover property (PSLVERR);
endmodule

bind keypad_led_display_control keypad_led_display_control_properties #(
	.EDIT_TIMEOUT_CYCLES(EDIT_TIMEOUT_CYCLES)
) u_keypad_led_display_control_properties (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .KEY_UP(KEY_UP), .KEY_DOWN(KEY_DOWN),
	.KEY_DIGIT(KEY_DIGIT), .KEY_ENTER(KEY_ENTER), .DISP_MODE(DISP_MODE),
	.FAULT_LED(FAULT_LED), .FORWARD_INDICATOR(FORWARD_INDICATOR),
	.REVERSE_INDICATOR(REVERSE_INDICATOR), .RUN_LED(RUN_LED),
	.SEQUENCE_SOURCE_INDICATOR(SEQUENCE_SOURCE_INDICATOR),
	.REFERENCE_SOURCE_INDICATOR(REFERENCE_SOURCE_INDICATOR)
);

// ### keypad_led_display_control_bench.sv
// ------------------------------------------------
// Bench for the keypad display controller
// ------------------------------------------------
module keypad_led_display_control_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TMO = 200;
	localparam logic [3:0] UP = 4'h1;
	localparam logic [3:0] DN = 4'h2;
	localparam logic [3:0] DIG = 4'h4;
	localparam logic [3:0] ENT = 4'h8;
	localparam logic [7:0] ST_TBL [5] = '{8'h0b, 8'h0e, 8'h6a, 8'h2e, 8'h0a};
	localparam logic [5:0] LED_TBL [5] = '{6'b110100, 6'b001100, 6'b010111, 6'b001110, 6'b010100};

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] keys = 4'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, er, frst;
	logic [19:0] dval;
	logic [4:0] dblank;
	logic [1:0] dmode;
	logic led_f, led_fw, led_rv, led_run, led_seq, led_ref, ph;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_rst = 0;

	keypad_led_display_control #(
		.EDIT_TIMEOUT_CYCLES(TMO), .HOLD_CYCLES(20), .REPEAT_CYCLES(5), .BLINK_HALF_CYCLES(8)
	) u_keypad_led_display_control (
		.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.KEY_UP(keys[0]), .KEY_DOWN(keys[1]), .KEY_DIGIT(keys[2]), .KEY_ENTER(keys[3]),
		.DISP_VALUE(dval), .DISP_BLANK(dblank), .DISP_MODE(dmode), .FAULT_LED(led_f),
		.FORWARD_INDICATOR(led_fw), .REVERSE_INDICATOR(led_rv), .RUN_LED(led_run),
		.SEQUENCE_SOURCE_INDICATOR(led_seq), .REFERENCE_SOURCE_INDICATOR(led_ref),
		.FAULT_RESET(frst)
	);

	// 20 MHz clock
	always #25 clk = ~clk;

	// ------------------------------------------------
	// Shared tasks
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Short presses stay below the hold time so no repeat starts
	task automatic press(input logic [3:0] k, input int n);
		@(posedge clk);
		keys <= k;
		repeat (n) @(posedge clk);
		keys <= 4'h0;
		repeat (6) @(posedge clk);
	endtask

	task automatic settle;
		repeat (6) @(posedge clk);
	endtask

	task automatic leds(input logic [5:0] e);
		chk({26'h0, led_f, led_fw, led_rv, led_run, led_seq, led_ref}, {26'h0, e});
	endtask

	task automatic give_verdict;
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Fault reset pulses, counted per cycle so a long pulse shows up
	always @(posedge clk)
	begin
		if (frst === 1'b1)
			n_rst <= n_rst + 1;
	end

	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk({30'h0, dmode}, 32'h0);
		leds(6'b111111);
		repeat (8) @(posedge clk);
		leds(6'b000000);
		rchk(kp_pkg::OFS_UPPER_LIMIT, 32'h06000);
		rchk(kp_pkg::OFS_PID_DIGITS, 32'h5);
		apb(1'b0, 8'h30, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, kp_pkg::OFS_DRIVE_STATUS, {24'h0, ST_TBL[i]});
			settle();
			leds(LED_TBL[i]);
		end
		// Digit key in display mode with a fault gives one reset pulse
		apb(1'b1, kp_pkg::OFS_DRIVE_STATUS, 32'h01);
		press(DIG, 4);
		chk(n_rst, 32'h1);
		// Forward selected and stopping: both flash in one phase
		apb(1'b1, kp_pkg::OFS_DRIVE_STATUS, 32'h10);
		settle();
		ph = led_fw;
		chk({31'h0, led_run}, {31'h0, ph});
		chk({31'h0, led_rv}, 32'h0);
		repeat (8) @(posedge clk);
		chk({30'h0, led_fw, led_run}, {30'h0, ~ph, ~ph});
		apb(1'b1, kp_pkg::OFS_DRIVE_STATUS, 32'h04);
		settle();
		chk({30'h0, led_fw, led_run}, 32'h0);
		// Running shows the output frequency
		apb(1'b1, kp_pkg::OFS_OUT_FREQ, 32'h01234);
		apb(1'b1, kp_pkg::OFS_DRIVE_STATUS, 32'h0a);
		settle();
		chk({10'h0, dmode, dval}, {10'h0, 2'h2, 20'h01234});
		apb(1'b1, kp_pkg::OFS_DRIVE_STATUS, 32'h00);
		apb(1'b1, kp_pkg::OFS_FREQ_REF, 32'h00500);
		settle();
		chk({10'h0, dmode, dval}, {10'h0, 2'h0, 20'h00500});
		// Edit, step, move digit, commit
		press(UP, 4);
		chk({10'h0, dmode, dval}, {10'h0, 2'h1, 20'h00500});
		press(UP, 4);
		chk({12'h0, dval}, 32'h00501);
		press(DIG, 4);
		chk({27'h0, dblank & 5'h1d}, 32'h0);
		ph = dblank[1];
		repeat (8) @(posedge clk);
		chk({31'h0, dblank[1]}, {31'h0, ~ph});
		press(UP, 4);
		chk({12'h0, dval}, 32'h00511);
		press(DN, 4);
		chk({12'h0, dval}, 32'h00501);
		press(ENT, 4);
		chk({30'h0, dmode}, 32'h0);
		rchk(kp_pkg::OFS_FREQ_REF, 32'h00501);
		// Wrap at both limits, then let the edit time out
		apb(1'b1, kp_pkg::OFS_UPPER_LIMIT, 32'h00503);
		press(UP, 4);
		press(UP, 4);
		press(UP, 4);
		press(UP, 4);
		chk({12'h0, dval}, 32'h00000);
		press(DN, 4);
		chk({12'h0, dval}, 32'h00503);
		repeat (TMO + 20) @(posedge clk);
		chk({30'h0, dmode}, 32'h0);
		rchk(kp_pkg::OFS_FREQ_REF, 32'h00501);
		// Held key: one step, then repeats after the hold time
		apb(1'b1, kp_pkg::OFS_UPPER_LIMIT, 32'h06000);
		press(UP, 4);
		press(UP, 33);
		chk({12'h0, dval}, 32'h00505);
		press(ENT, 4);
		// Monitor: analog as percent, PID width, slot selection
		apb(1'b1, kp_pkg::OFS_MON_SELECT, 32'h6005);
		apb(1'b1, kp_pkg::OFS_CTRL, 32'h1);
		apb(1'b1, kp_pkg::OFS_MON_VALUE, 32'h3ff);
		settle();
		chk({10'h0, dmode, dval}, {10'h0, 2'h3, 20'h00100});
		apb(1'b1, kp_pkg::OFS_MON_VALUE, 32'h200);
		settle();
		chk({12'h0, dval}, 32'h00050);
		apb(1'b0, kp_pkg::OFS_KP_STATUS, 32'h0);
		chk({29'h0, rd[14:12]}, 32'h6);
		apb(1'b1, kp_pkg::OFS_PID_DIGITS, 32'h3);
		apb(1'b1, kp_pkg::OFS_CTRL, 32'h9);
		settle();
		chk({27'h0, dblank}, 32'h18);
		apb(1'b0, kp_pkg::OFS_KP_STATUS, 32'h0);
		chk({29'h0, rd[14:12]}, 32'h5);
		apb(1'b1, kp_pkg::OFS_MON_SELECT, 32'h0);
		settle();
		chk({27'h0, dblank}, 32'h1f);
		chk(n_rst, 32'h1);
		give_verdict();
	end
endmodule
